// file: rtl/dmd_pkg.sv
package dmd_pkg;

  // memory geometry
  localparam int unsigned RAM_AW = 8;
  localparam int unsigned RAM_DEPTH = 256;
  localparam int unsigned XADDR_W = 16;

  // data memory map
  localparam logic [7:0] SP_RST = 8'h07;
  localparam logic [7:0] PSW_RST = 8'h00;
  localparam logic [7:0] BIT_BYTE_BASE = 8'h20;
  localparam int unsigned BANK_LSB = 3;
  localparam int unsigned BANK_MSB = 4;

  // program memory size codes and lock byte addresses
  localparam logic [1:0] SIZE_4K = 2'h0;
  localparam logic [1:0] SIZE_8K = 2'h1;
  localparam logic [1:0] SIZE_16K = 2'h2;
  localparam logic [15:0] LOCK_4K = 16'h0FFF;
  localparam logic [15:0] LOCK_8K = 16'h1FFF;
  localparam logic [15:0] LOCK_16K = 16'h3FFF;

  // register bus map
  localparam int unsigned AXI_AW = 8;
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_PSW = 8'h04;
  localparam logic [7:0] ADDR_SP = 8'h08;
  localparam logic [7:0] ADDR_STAT = 8'h0C;
  localparam int unsigned CTRL_FLASH_EN_BIT = 0;
  localparam int unsigned CTRL_RAM512_BIT = 1;
  localparam int unsigned CTRL_SIZE_LSB = 2;
  localparam logic [3:0] CTRL_RST = 4'hA;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  typedef enum logic [2:0] {DMD_OP_DATA, DMD_OP_PUSH, DMD_OP_POP, DMD_OP_CODE, DMD_OP_EXT} dmd_op_e;
  typedef enum logic [1:0] {DMD_MODE_DIRECT, DMD_MODE_INDIRECT, DMD_MODE_REGISTER} dmd_mode_e;
  typedef enum logic [2:0] {DMD_TGT_NONE, DMD_TGT_IRAM, DMD_TGT_SFR, DMD_TGT_ONCHIP_EXTERNAL_RAM, DMD_TGT_FLASH} dmd_tgt_e;
  typedef enum logic [2:0] {DMD_ST_IDLE, DMD_ST_PTR, DMD_ST_ACC, DMD_ST_WAIT, DMD_ST_RMW} dmd_state_e;

endpackage

// file: rtl/dmd_mem_if.sv
`timescale 1ns/1ps
`default_nettype none
interface dmd_mem_if;
  logic en;
  logic we;
  logic [dmd_pkg::RAM_AW-1:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  modport ctrl (output en, output we, output addr, output wdata, input rdata);
  modport ram (input en, input we, input addr, input wdata, output rdata);
endinterface
`default_nettype wire

// file: rtl/dmd_ram.sv
`timescale 1ns/1ps
`default_nettype none
module dmd_ram (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // array port
  dmd_mem_if.ram bus
);
  logic [7:0] mem [dmd_pkg::RAM_DEPTH];
  logic [7:0] rdata_ff;

  // array contents are not reset, only the read register is
  always_ff @(posedge clk_i) begin
    if (bus.en && bus.we) begin
      mem[bus.addr] <= bus.wdata;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_ff <= 8'h00;
    end else if (bus.en && !bus.we) begin
      rdata_ff <= mem[bus.addr];
    end
  end

  assign bus.rdata = rdata_ff;
endmodule
`default_nettype wire

// file: rtl/dmd_decoder.sv
// The AXI4-Lite slave port and the placing of the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
module dmd_decoder (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  // core request
  input wire logic core_req_i,
  input wire dmd_pkg::dmd_op_e core_op_i,
  input wire dmd_pkg::dmd_mode_e core_mode_i,
  input wire logic core_bit_i,
  input wire logic core_we_i,
  input wire logic [7:0] core_addr_i,
  input wire logic [dmd_pkg::XADDR_W-1:0] core_xaddr_i,
  input wire logic [7:0] core_wdata_i,
  output logic core_ready_o,
  output logic core_done_o,
  output logic [7:0] core_rdata_o,
  // special function space
  output logic sfr_en_o,
  output logic sfr_we_o,
  output logic [7:0] sfr_addr_o,
  output logic [7:0] sfr_wdata_o,
  input wire logic [7:0] sfr_rdata_i,
  // program flash
  output logic flash_en_o,
  output logic flash_we_o,
  output logic [dmd_pkg::XADDR_W-1:0] flash_addr_o,
  output logic [7:0] flash_wdata_o,
  input wire logic [7:0] flash_rdata_i,
  output logic [dmd_pkg::XADDR_W-1:0] lock_addr_o,
  output logic lock_hit_o,
  // register bus
  input wire logic axi_awvalid_i,
  output logic axi_awready_o,
  input wire logic [dmd_pkg::AXI_AW-1:0] axi_awaddr_i,
  input wire logic axi_wvalid_i,
  output logic axi_wready_o,
  input wire logic [31:0] axi_wdata_i,
  input wire logic [3:0] axi_wstrb_i,
  output logic axi_bvalid_o,
  input wire logic axi_bready_i,
  output logic [1:0] axi_bresp_o,
  input wire logic axi_arvalid_i,
  output logic axi_arready_o,
  input wire logic [dmd_pkg::AXI_AW-1:0] axi_araddr_i,
  output logic axi_rvalid_o,
  input wire logic axi_rready_i,
  output logic [31:0] axi_rdata_o,
  output logic [1:0] axi_rresp_o
);

  ////////////////////////////////////////////////////////////////////////////////
  dmd_pkg::dmd_state_e state_ff, nxt_state;
  dmd_pkg::dmd_op_e op_ff;
  dmd_pkg::dmd_mode_e mode_ff;
  dmd_pkg::dmd_tgt_e tgt_ff, tgt_sel;
  logic bit_ff, we_ff;
  logic [7:0] addr_ff, wdata_ff, tgt_addr_ff, rbyte_ff, sp_ff, psw_ff, rdata_ff;
  logic [dmd_pkg::XADDR_W-1:0] xaddr_ff, lock_addr_ff, flash_addr_ff;
  logic [3:0] ctrl_ff;
  logic done_ff, sfr_en_ff, sfr_we_ff, flash_en_ff, flash_we_ff, lock_hit_ff;
  logic [7:0] sfr_addr_ff, sfr_wdata_ff, flash_wdata_ff;

  dmd_mem_if iram_bus ();
  dmd_mem_if onchip_external_ram_bus ();

  // one array holds lower and upper ram; the special function space lives outside
  dmd_ram u_iram (
    .clk_i(core_clk_i),
    .rst_i(rst_i),
    .bus(iram_bus)
  );

  dmd_ram u_onchip_external_ram (
    .clk_i(core_clk_i),
    .rst_i(rst_i),
    .bus(onchip_external_ram_bus)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // decode
  logic st_idle, st_ptr, st_acc, st_wait, st_rmw;
  logic op_data, op_push, op_pop, op_code, op_ext;
  logic md_direct, md_indirect, md_register;
  logic flash_cfg, ram512_cfg, acc_we, rmw_needed, take_req;
  logic [1:0] bank_sel, size_cfg;
  logic [7:0] ptr_addr, reg_addr, bit_byte_addr, mode_addr, data_addr, acc_addr;
  logic [7:0] cap_byte, merged;
  logic [dmd_pkg::XADDR_W-1:0] lock_sel;
  logic cap_bit;

  assign st_idle = state_ff == dmd_pkg::DMD_ST_IDLE;
  assign st_ptr = state_ff == dmd_pkg::DMD_ST_PTR;
  assign st_acc = state_ff == dmd_pkg::DMD_ST_ACC;
  assign st_wait = state_ff == dmd_pkg::DMD_ST_WAIT;
  assign st_rmw = state_ff == dmd_pkg::DMD_ST_RMW;
  assign op_data = op_ff == dmd_pkg::DMD_OP_DATA;
  assign op_push = op_ff == dmd_pkg::DMD_OP_PUSH;
  assign op_pop = op_ff == dmd_pkg::DMD_OP_POP;
  assign op_code = op_ff == dmd_pkg::DMD_OP_CODE;
  assign op_ext = op_ff == dmd_pkg::DMD_OP_EXT;
  assign md_indirect = mode_ff == dmd_pkg::DMD_MODE_INDIRECT;
  assign md_register = mode_ff == dmd_pkg::DMD_MODE_REGISTER;
  // the unused mode code behaves as direct
  assign md_direct = !md_indirect && !md_register;

  assign flash_cfg = ctrl_ff[dmd_pkg::CTRL_FLASH_EN_BIT];
  assign ram512_cfg = ctrl_ff[dmd_pkg::CTRL_RAM512_BIT];
  assign size_cfg = ctrl_ff[dmd_pkg::CTRL_SIZE_LSB +: 2];
  assign bank_sel = psw_ff[dmd_pkg::BANK_MSB:dmd_pkg::BANK_LSB];

  // pointer is register zero or one of the active bank
  assign ptr_addr = {3'b000, bank_sel, 2'b00, addr_ff[0]};
  assign reg_addr = {3'b000, bank_sel, addr_ff[2:0]};
  // bits 0x00-0x7F sit in bytes 0x20-0x2F, bits above map onto aligned sfr bytes
  assign bit_byte_addr = addr_ff[7] ? {addr_ff[7:3], 3'b000}
                                    : dmd_pkg::BIT_BYTE_BASE + {4'h0, addr_ff[6:3]};
  // during the access the ram read register still holds the fetched pointer
  assign mode_addr = md_indirect ? iram_bus.rdata : (md_register ? reg_addr : addr_ff);
  assign data_addr = (bit_ff && md_direct) ? bit_byte_addr : mode_addr;
  assign acc_addr = op_push ? sp_ff + 8'h01 : (op_pop ? sp_ff : (op_ext ? xaddr_ff[7:0] : data_addr));
  assign acc_we = op_push || (we_ff && !bit_ff && (op_data || op_ext));
  assign rmw_needed = we_ff && bit_ff && op_data;
  assign take_req = st_idle && core_req_i;

  always_comb begin
    tgt_sel = dmd_pkg::DMD_TGT_NONE;
    unique case (op_ff)
      dmd_pkg::DMD_OP_DATA: begin
        // above 0x7F only direct mode reaches the special function space
        tgt_sel = (md_direct && data_addr[7]) ? dmd_pkg::DMD_TGT_SFR : dmd_pkg::DMD_TGT_IRAM;
      end
      dmd_pkg::DMD_OP_PUSH, dmd_pkg::DMD_OP_POP: begin
        tgt_sel = dmd_pkg::DMD_TGT_IRAM;
      end
      dmd_pkg::DMD_OP_CODE: begin
        tgt_sel = dmd_pkg::DMD_TGT_FLASH;
      end
      dmd_pkg::DMD_OP_EXT: begin
        if (we_ff && flash_cfg) begin
          tgt_sel = dmd_pkg::DMD_TGT_FLASH;
        end else if (ram512_cfg) begin
          tgt_sel = dmd_pkg::DMD_TGT_ONCHIP_EXTERNAL_RAM;
        end else begin
          tgt_sel = dmd_pkg::DMD_TGT_NONE;
        end
      end
      default: begin
        tgt_sel = dmd_pkg::DMD_TGT_NONE;
      end
    endcase
  end

  assign cap_byte = (tgt_ff == dmd_pkg::DMD_TGT_IRAM) ? iram_bus.rdata :
                    (tgt_ff == dmd_pkg::DMD_TGT_ONCHIP_EXTERNAL_RAM) ? onchip_external_ram_bus.rdata :
                    (tgt_ff == dmd_pkg::DMD_TGT_SFR) ? sfr_rdata_i :
                    (tgt_ff == dmd_pkg::DMD_TGT_FLASH) ? flash_rdata_i : 8'h00;
  assign cap_bit = cap_byte[addr_ff[2:0]];

  // bit write: replace one bit of the byte read back in the wait state
  for (genvar i = 0; i < 8; i++) begin : g_merge
    assign merged[i] = (addr_ff[2:0] == 3'(i)) ? wdata_ff[0] : rbyte_ff[i];
  end

  assign lock_sel = (size_cfg == dmd_pkg::SIZE_4K) ? dmd_pkg::LOCK_4K :
                    (size_cfg == dmd_pkg::SIZE_8K) ? dmd_pkg::LOCK_8K : dmd_pkg::LOCK_16K;

  ////////////////////////////////////////////////////////////////////////////////
  // ram ports
  assign iram_bus.en = st_ptr || (st_acc && tgt_sel == dmd_pkg::DMD_TGT_IRAM) ||
                       (st_rmw && tgt_ff == dmd_pkg::DMD_TGT_IRAM);
  assign iram_bus.we = (st_acc && tgt_sel == dmd_pkg::DMD_TGT_IRAM && acc_we) ||
                       (st_rmw && tgt_ff == dmd_pkg::DMD_TGT_IRAM);
  assign iram_bus.addr = st_ptr ? ptr_addr : (st_rmw ? tgt_addr_ff : acc_addr);
  assign iram_bus.wdata = st_rmw ? merged : wdata_ff;
  assign onchip_external_ram_bus.en = st_acc && tgt_sel == dmd_pkg::DMD_TGT_ONCHIP_EXTERNAL_RAM;
  assign onchip_external_ram_bus.we = st_acc && tgt_sel == dmd_pkg::DMD_TGT_ONCHIP_EXTERNAL_RAM && acc_we;
  assign onchip_external_ram_bus.addr = xaddr_ff[7:0];
  assign onchip_external_ram_bus.wdata = wdata_ff;

  ////////////////////////////////////////////////////////////////////////////////
  // sequencer
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      dmd_pkg::DMD_ST_IDLE: begin
        if (core_req_i) begin
          if (core_op_i == dmd_pkg::DMD_OP_DATA && core_mode_i == dmd_pkg::DMD_MODE_INDIRECT) begin
            nxt_state = dmd_pkg::DMD_ST_PTR;
          end else begin
            nxt_state = dmd_pkg::DMD_ST_ACC;
          end
        end
      end
      dmd_pkg::DMD_ST_PTR: begin
        nxt_state = dmd_pkg::DMD_ST_ACC;
      end
      dmd_pkg::DMD_ST_ACC: begin
        nxt_state = dmd_pkg::DMD_ST_WAIT;
      end
      dmd_pkg::DMD_ST_WAIT: begin
        nxt_state = rmw_needed ? dmd_pkg::DMD_ST_RMW : dmd_pkg::DMD_ST_IDLE;
      end
      dmd_pkg::DMD_ST_RMW: begin
        nxt_state = dmd_pkg::DMD_ST_IDLE;
      end
      default: begin
        nxt_state = dmd_pkg::DMD_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_ff <= dmd_pkg::DMD_ST_IDLE;
      op_ff <= dmd_pkg::DMD_OP_DATA;
      mode_ff <= dmd_pkg::DMD_MODE_DIRECT;
      bit_ff <= 1'b0;
      we_ff <= 1'b0;
      addr_ff <= 8'h00;
      xaddr_ff <= 16'h0000;
      wdata_ff <= 8'h00;
    end else begin
      state_ff <= nxt_state;
      if (take_req) begin
        op_ff <= core_op_i;
        mode_ff <= core_mode_i;
        bit_ff <= core_bit_i;
        we_ff <= core_we_i;
        addr_ff <= core_addr_i;
        xaddr_ff <= core_xaddr_i;
        wdata_ff <= core_wdata_i;
      end
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      tgt_ff <= dmd_pkg::DMD_TGT_NONE;
      tgt_addr_ff <= 8'h00;
      rbyte_ff <= 8'h00;
      rdata_ff <= 8'h00;
      done_ff <= 1'b0;
    end else begin
      done_ff <= (st_wait && !rmw_needed) || st_rmw;
      if (st_acc) begin
        tgt_ff <= tgt_sel;
        tgt_addr_ff <= acc_addr;
      end
      if (st_wait) begin
        rbyte_ff <= cap_byte;
        rdata_ff <= bit_ff ? {7'h00, cap_bit} : cap_byte;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // outside strobes, registered so that they show one cycle after the access state or the read-modify-write state
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      sfr_en_ff <= 1'b0;
      sfr_we_ff <= 1'b0;
      sfr_addr_ff <= 8'h00;
      sfr_wdata_ff <= 8'h00;
      flash_en_ff <= 1'b0;
      flash_we_ff <= 1'b0;
      flash_addr_ff <= 16'h0000;
      flash_wdata_ff <= 8'h00;
      lock_hit_ff <= 1'b0;
      lock_addr_ff <= dmd_pkg::LOCK_16K;
    end else begin
      sfr_en_ff <= (st_acc && tgt_sel == dmd_pkg::DMD_TGT_SFR) || (st_rmw && tgt_ff == dmd_pkg::DMD_TGT_SFR);
      sfr_we_ff <= (st_acc && tgt_sel == dmd_pkg::DMD_TGT_SFR && acc_we) || (st_rmw && tgt_ff == dmd_pkg::DMD_TGT_SFR);
      if (st_acc && tgt_sel == dmd_pkg::DMD_TGT_SFR) begin
        sfr_addr_ff <= acc_addr;
        sfr_wdata_ff <= wdata_ff;
      end else if (st_rmw && tgt_ff == dmd_pkg::DMD_TGT_SFR) begin
        sfr_wdata_ff <= merged;
      end
      flash_en_ff <= st_acc && tgt_sel == dmd_pkg::DMD_TGT_FLASH;
      flash_we_ff <= st_acc && tgt_sel == dmd_pkg::DMD_TGT_FLASH && op_ext;
      lock_hit_ff <= st_acc && tgt_sel == dmd_pkg::DMD_TGT_FLASH && xaddr_ff == lock_addr_ff;
      if (st_acc && tgt_sel == dmd_pkg::DMD_TGT_FLASH) begin
        flash_addr_ff <= xaddr_ff;
        flash_wdata_ff <= wdata_ff;
      end
      lock_addr_ff <= lock_sel;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // register bus slave
  logic aw_held_ff, w_held_ff, bvalid_ff, rvalid_ff;
  logic [dmd_pkg::AXI_AW-1:0] aw_addr_ff;
  logic [31:0] w_data_ff, axi_rdata_ff, rd_word, stat_word;
  logic [3:0] w_strb_ff;
  logic [1:0] bresp_ff, rresp_ff;
  logic wr_commit, wr_lane0, wr_mapped, rd_mapped, wr_ctrl, wr_psw, wr_sp;

  assign axi_awready_o = !aw_held_ff && !bvalid_ff;
  assign axi_wready_o = !w_held_ff && !bvalid_ff;
  assign axi_arready_o = !rvalid_ff;
  assign wr_commit = aw_held_ff && w_held_ff;
  assign wr_lane0 = wr_commit && w_strb_ff[0];
  assign wr_ctrl = wr_lane0 && aw_addr_ff == dmd_pkg::ADDR_CTRL;
  assign wr_psw = wr_lane0 && aw_addr_ff == dmd_pkg::ADDR_PSW;
  assign wr_sp = wr_lane0 && aw_addr_ff == dmd_pkg::ADDR_SP;
  assign wr_mapped = aw_addr_ff == dmd_pkg::ADDR_CTRL || aw_addr_ff == dmd_pkg::ADDR_PSW ||
                     aw_addr_ff == dmd_pkg::ADDR_SP || aw_addr_ff == dmd_pkg::ADDR_STAT;
  assign rd_mapped = axi_araddr_i == dmd_pkg::ADDR_CTRL || axi_araddr_i == dmd_pkg::ADDR_PSW ||
                     axi_araddr_i == dmd_pkg::ADDR_SP || axi_araddr_i == dmd_pkg::ADDR_STAT;
  assign stat_word = {13'h0000, bank_sel, !st_idle, lock_addr_ff};
  assign rd_word = (axi_araddr_i == dmd_pkg::ADDR_CTRL) ? {28'h0000000, ctrl_ff} :
                   (axi_araddr_i == dmd_pkg::ADDR_PSW) ? {24'h000000, psw_ff} :
                   (axi_araddr_i == dmd_pkg::ADDR_SP) ? {24'h000000, sp_ff} :
                   (axi_araddr_i == dmd_pkg::ADDR_STAT) ? stat_word : 32'h00000000;

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      aw_held_ff <= 1'b0;
      aw_addr_ff <= 8'h00;
      w_held_ff <= 1'b0;
      w_data_ff <= 32'h00000000;
      w_strb_ff <= 4'h0;
      bvalid_ff <= 1'b0;
      bresp_ff <= dmd_pkg::RESP_OKAY;
    end else begin
      if (axi_awvalid_i && axi_awready_o) begin
        aw_held_ff <= 1'b1;
        aw_addr_ff <= axi_awaddr_i;
      end else if (wr_commit) begin
        aw_held_ff <= 1'b0;
      end
      if (axi_wvalid_i && axi_wready_o) begin
        w_held_ff <= 1'b1;
        w_data_ff <= axi_wdata_i;
        w_strb_ff <= axi_wstrb_i;
      end else if (wr_commit) begin
        w_held_ff <= 1'b0;
      end
      if (wr_commit) begin
        bvalid_ff <= 1'b1;
        bresp_ff <= wr_mapped ? dmd_pkg::RESP_OKAY : dmd_pkg::RESP_DECERR;
      end else if (axi_bready_i) begin
        bvalid_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rvalid_ff <= 1'b0;
      axi_rdata_ff <= 32'h00000000;
      rresp_ff <= dmd_pkg::RESP_OKAY;
    end else if (axi_arvalid_i && axi_arready_o) begin
      rvalid_ff <= 1'b1;
      axi_rdata_ff <= rd_word;
      rresp_ff <= rd_mapped ? dmd_pkg::RESP_OKAY : dmd_pkg::RESP_DECERR;
    end else if (axi_rready_i) begin
      rvalid_ff <= 1'b0;
    end
  end

  // a push or pop in the same cycle as a software write to the pointer wins
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      sp_ff <= dmd_pkg::SP_RST;
      psw_ff <= dmd_pkg::PSW_RST;
      ctrl_ff <= dmd_pkg::CTRL_RST;
    end else begin
      if (st_acc && op_push) begin
        sp_ff <= sp_ff + 8'h01;
      end else if (st_acc && op_pop) begin
        sp_ff <= sp_ff - 8'h01;
      end else if (wr_sp) begin
        sp_ff <= w_data_ff[7:0];
      end
      if (wr_psw) begin
        psw_ff <= w_data_ff[7:0];
      end
      if (wr_ctrl) begin
        ctrl_ff <= w_data_ff[3:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  assign core_ready_o = st_idle;
  assign core_done_o = done_ff;
  assign core_rdata_o = rdata_ff;
  assign sfr_en_o = sfr_en_ff;
  assign sfr_we_o = sfr_we_ff;
  assign sfr_addr_o = sfr_addr_ff;
  assign sfr_wdata_o = sfr_wdata_ff;
  assign flash_en_o = flash_en_ff;
  assign flash_we_o = flash_we_ff;
  assign flash_addr_o = flash_addr_ff;
  assign flash_wdata_o = flash_wdata_ff;
  assign lock_addr_o = lock_addr_ff;
  assign lock_hit_o = lock_hit_ff;
  assign axi_bvalid_o = bvalid_ff;
  assign axi_bresp_o = bresp_ff;
  assign axi_rvalid_o = rvalid_ff;
  assign axi_rdata_o = axi_rdata_ff;
  assign axi_rresp_o = rresp_ff;

  ////////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);

  a_sp_reset_value: assert property ($fell(rst_i) |-> sp_ff == 8'h07)
    else $error("stack pointer not 0x07 after reset");
  a_push_store: assert property ((st_acc && op_push) |-> (iram_bus.we && iram_bus.addr == sp_ff + 8'h01)
                                 ##1 (sp_ff == $past(iram_bus.addr)))
    else $error("push did not store at pointer plus one then increment");
  a_pop_read: assert property ((st_acc && op_pop) |-> (iram_bus.en && !iram_bus.we && iram_bus.addr == sp_ff)
                               ##1 (sp_ff == $past(sp_ff) - 8'h01))
    else $error("pop did not read at pointer then decrement");
  a_direct_sfr_route: assert property ((st_acc && op_data && md_direct && !bit_ff && addr_ff[7])
                                       |-> !iram_bus.en ##1 (sfr_en_o && sfr_addr_o == $past(addr_ff)))
    else $error("direct upper access not sent to special function space");
  a_indirect_upper_ram: assert property ((st_acc && op_data && md_indirect)
                                         |-> (iram_bus.en && iram_bus.addr == iram_bus.rdata) ##1 !sfr_en_o)
    else $error("indirect access not sent to internal ram");
  a_pointer_bank: assert property (st_ptr |-> (iram_bus.addr[7:5] == 3'h0 && iram_bus.addr[2:1] == 2'h0 &&
                                               iram_bus.addr[4:3] == psw_ff[4:3] && !iram_bus.we))
    else $error("pointer fetch outside the active bank");
  a_register_window: assert property ((st_acc && op_data && md_register)
                                      |-> iram_bus.addr == 8'(psw_ff[4:3]) * 8'h08 + 8'(addr_ff[2:0]))
    else $error("register access outside bank window");
  a_bit_byte_map: assert property ((st_acc && op_data && md_direct && bit_ff && !addr_ff[7])
                                   |-> (iram_bus.addr == 8'h20 + 8'(addr_ff[6:3]) && !iram_bus.we))
    else $error("bit address mapped to wrong byte");
  a_flash_write_route: assert property ((st_acc && op_ext && we_ff && flash_cfg)
                                        |-> !onchip_external_ram_bus.en ##1 (flash_en_o && flash_we_o && flash_addr_o == $past(xaddr_ff)))
    else $error("external move write not sent to flash");
  a_onchip_external_ram_route: assert property ((st_acc && op_ext && !flash_cfg && ram512_cfg)
                                 |-> (onchip_external_ram_bus.en && !iram_bus.en) ##1 !flash_en_o)
    else $error("external move not sent to onchip external ram");
  a_code_read: assert property ((st_acc && op_code) |=> (flash_en_o && !flash_we_o))
    else $error("code move did not read flash");
  a_lock_addr_8k: assert property ((size_cfg == 2'h1) [*2] |-> lock_addr_o == 16'h1FFF)
    else $error("lock byte address wrong for 8 kB");

endmodule
`default_nettype wire

// file: test/dmd_far_model.sv
`timescale 1ns/1ps
`default_nettype none
module dmd_far_model (
  // clock
  input wire logic clk_i,
  // special function space
  input wire logic sfr_en_i,
  input wire logic sfr_we_i,
  input wire logic [7:0] sfr_addr_i,
  input wire logic [7:0] sfr_wdata_i,
  output logic [7:0] sfr_rdata_o,
  // program flash
  input wire logic flash_en_i,
  input wire logic flash_we_i,
  input wire logic [15:0] flash_addr_i,
  input wire logic [7:0] flash_wdata_i,
  output logic [7:0] flash_rdata_o
);
  logic [7:0] sfr_mem [256];
  logic [7:0] fl_mem [256];
  // idle lines show the inverse, so a stale sample never matches
  assign sfr_rdata_o = sfr_en_i ? sfr_mem[sfr_addr_i] : ~sfr_mem[sfr_addr_i];
  assign flash_rdata_o = flash_en_i ? fl_mem[flash_addr_i[7:0]] : ~fl_mem[flash_addr_i[7:0]];
  initial for (int i = 0; i < 256; i++) begin
    sfr_mem[i] = 8'hC3;
    fl_mem[i] = 8'(i) ^ 8'h5A;
  end
  always @(posedge clk_i) begin
    if (sfr_en_i && sfr_we_i) sfr_mem[sfr_addr_i] <= sfr_wdata_i;
    if (flash_en_i && flash_we_i) fl_mem[flash_addr_i[7:0]] <= flash_wdata_i;
  end
endmodule
`default_nettype wire

// file: test/data_memory_map_decoder_test.sv
`timescale 1ns/1ps
`default_nettype none
module data_memory_map_decoder_test;
  logic core_clk_i = '0, rst_i = '1, core_req_i = '0, core_bit_i = '0, core_we_i = '0, lock_hit_o;
  dmd_pkg::dmd_op_e core_op_i = dmd_pkg::DMD_OP_DATA;
  dmd_pkg::dmd_mode_e core_mode_i = dmd_pkg::DMD_MODE_DIRECT;
  logic [7:0] core_addr_i = '0, core_wdata_i = '0, axi_awaddr_i = '0, axi_araddr_i = '0, core_rdata_o;
  logic [7:0] sfr_addr_o, sfr_wdata_o, sfr_rdata_i, flash_wdata_o, flash_rdata_i, v;
  logic [15:0] core_xaddr_i = '0, flash_addr_o, lock_addr_o;
  logic [31:0] axi_wdata_i = '0, axi_rdata_o;
  logic [3:0] axi_wstrb_i = 4'hF;
  logic [1:0] axi_bresp_o, axi_rresp_o;
  logic axi_awvalid_i = '0, axi_wvalid_i = '0, axi_bready_i = '0, axi_arvalid_i = '0, axi_rready_i = '0;
  logic core_ready_o, core_done_o, sfr_en_o, sfr_we_o, flash_en_o, flash_we_o;
  logic axi_awready_o, axi_wready_o, axi_bvalid_o, axi_arready_o, axi_rvalid_o;
  logic [9:0] ce, cq[$];
  logic hit = 1'b0;
  logic [33:0] aq[$];
  int n_fail = 0, n_checks = 0;
  dmd_decoder i_dut (.*);
  dmd_far_model i_far (.clk_i(core_clk_i), .sfr_en_i(sfr_en_o), .sfr_we_i(sfr_we_o), .sfr_addr_i(sfr_addr_o),
    .sfr_wdata_i(sfr_wdata_o), .sfr_rdata_o(sfr_rdata_i), .flash_en_i(flash_en_o), .flash_we_i(flash_we_o),
    .flash_addr_i(flash_addr_o), .flash_wdata_i(flash_wdata_o), .flash_rdata_o(flash_rdata_i));
  always #25 core_clk_i = ~core_clk_i;
  ////////////////////////
  task automatic cmp(input string n, input logic [33:0] e, input logic [33:0] g);
    n_checks++;
    if (e !== g) begin
      n_fail++;
      $display("unexpected %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // e[8] set means the read byte is compared, e[9] is the expected lock hit; xaddr is {d, a}
  task automatic cr(input logic [2:0] o, m, input logic b, w, input logic [7:0] a, d, input logic [9:0] e);
    @(posedge core_clk_i);
    cq.push_back(e);
    core_op_i <= dmd_pkg::dmd_op_e'(o);
    core_mode_i <= dmd_pkg::dmd_mode_e'(m);
    {core_bit_i, core_we_i, core_addr_i, core_wdata_i, core_xaddr_i} <= {b, w, a, d, d, a};
    core_req_i <= 1'b1;
    do @(posedge core_clk_i); while (core_ready_o !== 1'b1);
    core_req_i <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    logic ta, tw;
    {ta, tw} = 2'h0;
    @(posedge core_clk_i);
    {axi_awaddr_i, axi_wdata_i} <= {a, d};
    {axi_awvalid_i, axi_wvalid_i, axi_bready_i} <= 3'h7;
    do begin
      @(posedge core_clk_i);
      if (!ta && axi_awready_o === 1'b1) begin ta = 1; axi_awvalid_i <= 1'b0; end
      if (!tw && axi_wready_o === 1'b1) begin tw = 1; axi_wvalid_i <= 1'b0; end
    end while (axi_bvalid_o !== 1'b1);
    axi_bready_i <= 1'b0;
    cmp("axi_bresp", r, axi_bresp_o);
  endtask
  task automatic rd(input logic [7:0] a, input logic [33:0] e);
    @(posedge core_clk_i);
    aq.push_back(e);
    {axi_araddr_i, axi_arvalid_i, axi_rready_i} <= {a, 2'h3};
    do @(posedge core_clk_i); while (axi_arready_o !== 1'b1);
    axi_arvalid_i <= 1'b0;
    do @(posedge core_clk_i); while (axi_rvalid_o !== 1'b1);
    axi_rready_i <= 1'b0;
  endtask
  ////////////////////////
  always @(posedge core_clk_i) begin
    if (lock_hit_o === 1'b1) hit = 1'b1;
    if (core_done_o === 1'b1) begin
      ce = cq.pop_front();
      if (ce[8]) cmp("core_rdata", ce[7:0], core_rdata_o);
      cmp("lock_hit", ce[9], hit);
      hit = 1'b0;
    end
    if (axi_rvalid_o === 1'b1 && axi_rready_i) cmp("axi_read", aq.pop_front(), {axi_rresp_o, axi_rdata_o});
  end
  initial begin
    #250000;
    n_fail++;
    close_out();
  end
  initial begin
    void'($urandom(32'h4F6B));
    repeat (2) @(posedge core_clk_i);
    rst_i <= 1'b0;
    cr(1, 0, 0, 1, 0, 8'h11, 0);
    cr(0, 0, 0, 0, 8'h08, 0, 9'h111);
    cr(2, 0, 0, 0, 0, 0, 9'h111);
    rd(8'h08, 34'h7);
    wr(8'h08, 32'hFF, 2'h0);
    cr(1, 0, 0, 1, 0, 8'hE4, 0);
    cr(0, 0, 0, 0, 8'h00, 0, 9'h1E4);
    rd(8'h08, 34'h0);
    $display("stack test done");
    for (int k = 0; k < 4; k++) begin
      v = 8'($urandom);
      wr(8'h04, k << 3, 2'h0);
      cr(0, 2, 0, 1, 8'(k), v, 0);
      cr(0, 0, 0, 0, 8'(9 * k), 0, {1'b1, v});
    end
    cr(0, 2, 0, 1, 0, 8'h90, 0);
    cr(0, 1, 0, 1, 0, 8'hA5, 0);
    cr(0, 0, 0, 1, 8'h90, 8'h3C, 0);
    cr(0, 1, 0, 0, 0, 0, 9'h1A5);
    cr(0, 0, 0, 0, 8'h90, 0, 9'h13C);
    cr(0, 2, 0, 1, 1, 8'h40, 0);
    cr(0, 1, 0, 1, 1, 8'h77, 0);
    cr(0, 0, 0, 0, 8'h40, 0, 9'h177);
    cr(0, 3, 0, 0, 8'h40, 0, 9'h177);
    $display("bank test done");
    cr(0, 0, 0, 1, 8'h22, 8'h81, 0);
    cr(0, 0, 1, 1, 8'h13, 1, 0);
    cr(0, 0, 0, 0, 8'h22, 0, 9'h189);
    cr(0, 0, 1, 0, 8'h17, 0, 9'h101);
    cr(0, 0, 1, 1, 8'h93, 0, 0);
    cr(0, 0, 0, 0, 8'h90, 0, 9'h134);
    cr(4, 0, 0, 1, 8'h33, 8'h6E, 0);
    cr(4, 0, 0, 0, 8'h33, 0, 9'h16E);
    cr(3, 0, 0, 0, 8'h33, 0, 9'h169);
    wr(8'h00, 32'hB, 2'h0);
    cr(4, 0, 0, 1, 8'h33, 8'hD2, 0);
    cr(3, 0, 0, 0, 8'h33, 0, 9'h1D2);
    cr(4, 0, 0, 0, 8'h33, 0, 9'h16E);
    cr(3, 0, 0, 0, 8'hFF, 8'h3F, 10'h3A5);
    $display("bit and flash test done");
    for (int k = 0; k < 3; k++) begin
      wr(8'h00, {k[1:0], 2'h2}, 2'h0);
      rd(8'h0C, 34'(32'h60000 | ((32'h1000 << k) - 1)));
      cmp("lock_addr", 34'((32'h1000 << k) - 1), lock_addr_o);
    end
    wr(8'h00, 32'h8, 2'h0);
    cr(4, 0, 0, 1, 8'h33, 8'h99, 0);
    cr(4, 0, 0, 0, 8'h33, 0, 9'h100);
    wr(8'h00, 32'hA, 2'h0);
    cr(4, 0, 0, 0, 8'h33, 0, 9'h16E);
    rd(8'h40, {2'h3, 32'h0});
    wr(8'h40, 32'h5, 2'h3);
    $display("lock and map test done");
    close_out();
  end
endmodule
`default_nettype wire
